/* core/fsr_top.sv */
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// What this block does
// - A region is writable only when its volatile and persistent protect bits are zero.
// - While suspended, reads succeed everywhere except the suspended page, sector or block.
// - Suspend waits its latency, then clears write latch and sets the suspended flag.
// - After latency, reads, IDs, mode, secure, burst, lock reads, latch set, resume pass.
// - Page program opcodes are accepted during erase suspend only, never program suspend.
// - Latch clear, status reads, signature, reset arm, reset, no-op pass anytime.
// - Security bit 2 shows program suspended, bit 3 erase suspended; resume clears.
// - Erase suspend permits page program of unprotected memory outside the region.
// - A program started inside erase suspend cannot be suspended; host waits for it.
// - That nested program holds write latch and busy high, clearing both at completion.
// - Resume sets write latch and busy, clears suspended flag, continues the operation.
// - Resume is ignored in performance enhance mode.
// - No-op only cancels a pending reset arm; eight or two clocks per opcode.
// - Reset acts only directly after reset arm; any other command cancels arm.
// - Software reset returns to standby with volatile state, except the performance enhance bit, at power-on defaults.
// - Software reset aborts a running program or erase.
module fsr_top
   import fsr_pkg::*;
#(
   parameter logic [7:0] SUSPEND_OP  = OP_SUSP_DEF,
   parameter int         P_SUSP_NS   = 20000,
   parameter int         E_SUSP_NS   = 20000,
   parameter int         P_GAP_NS    = 20000,
   parameter int         E_GAP_NS    = 20000,
   parameter int         PROG_NS     = 100000,
   parameter int         ERASE_NS    = 400000
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  sio_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o
);
   localparam logic [23:0] PROG_CYC  = 24'(fsr_cyc_up(PROG_NS));
   localparam logic [23:0] ERASE_CYC = 24'(fsr_cyc_up(ERASE_NS));
   localparam logic [23:0] P_SL_CYC  = 24'(fsr_cyc_up(P_SUSP_NS));
   localparam logic [23:0] E_SL_CYC  = 24'(fsr_cyc_up(E_SUSP_NS));
   localparam logic [23:0] P_GAP_CYC = 24'(fsr_cyc_up(P_GAP_NS));
   localparam logic [23:0] E_GAP_CYC = 24'(fsr_cyc_up(E_GAP_NS));

   typedef struct packed {
      fsr_state_t  st;
      fsr_opk_t    opk;
      logic [23:0] addr;
      logic [23:0] cnt;
      logic [23:0] sav;
      logic [23:0] lat;
      logic        write_enable_latch;
      logic        write_in_progress;
      logic        program_suspended_flag;
      logic        erase_suspended_flag;
      logic        quad;
      logic        armed;
      logic        rdok;
      logic        perf;
      logic [15:0] vol;
      logic [15:0] pers;
      logic [7:0]  last_op;
      logic        last_acc;
      logic        ack;
      logic [31:0] dat;
   } fsr_core_t;

   fsr_core_t q;
   fsr_core_t n;
   logic      acc;
   logic      hit;
   logic      prot;
   logic      idle;
   logic      sus;

   fsr_cmd_if lk ();

   fsr_cmd_shift u_shift (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .sclk_i (sclk_i),
      .cs_n_i (cs_n_i),
      .sio_i  (sio_i),
      .lk     (lk.shifter)
   );

   function automatic logic in_region(logic [23:0] a, logic [23:0] b, fsr_opk_t k);
      unique case (k)
         OPK_PROG: return a[ADR_W-1:PAGE_LSB] == b[ADR_W-1:PAGE_LSB];
         OPK_E4K:  return a[ADR_W-1:SEC_LSB] == b[ADR_W-1:SEC_LSB];
         OPK_E32K: return a[ADR_W-1:B32_LSB] == b[ADR_W-1:B32_LSB];
         OPK_E64K: return a[ADR_W-1:B64_LSB] == b[ADR_W-1:B64_LSB];
      endcase
   endfunction

   always_comb begin
      n    = q;
      acc  = 1'b0;
      idle = (q.st == ST_IDLE);
      sus  = (q.st == ST_SUSP);
      hit  = in_region(lk.addr, q.addr, q.opk);
      prot = q.vol[lk.addr[ADR_W-1:REG_LSB]] | q.pers[lk.addr[ADR_W-1:REG_LSB]];

      // Bus slave: one wait state, data captured from the state seen at the request.
      n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
      n.dat = '0;
      if (n.ack) begin
         unique case (wb_adr_i)
            A_STATUS: begin
               n.dat[B_WIP]  = q.write_in_progress;
               n.dat[B_WEL]  = q.write_enable_latch;
               n.dat[B_PSB]  = q.program_suspended_flag;
               n.dat[B_ESB]  = q.erase_suspended_flag;
               n.dat[B_QUAD] = q.quad;
               n.dat[B_ARM]  = q.armed;
               n.dat[B_RDOK] = q.rdok;
               n.dat[B_BUSY] = ~idle;
            end
            A_SECUR: begin
               n.dat[SEC_PSB] = q.program_suspended_flag;
               n.dat[SEC_ESB] = q.erase_suspended_flag;
            end
            A_VOL:   n.dat[15:0] = q.vol;
            A_PERS:  n.dat[15:0] = q.pers;
            A_CTRL:  n.dat[0] = q.perf;
            A_LAST:  n.dat[LAST_ACC:0] = {q.last_acc, q.last_op};
            default: n.dat = '0;
         endcase
      end
      if (q.ack && wb_cyc_i && wb_stb_i && wb_we_i) begin
         for (int b = 0; b < 2; b++) begin
            if (wb_sel_i[b] && wb_adr_i == A_VOL) n.vol[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            if (wb_sel_i[b] && wb_adr_i == A_PERS) n.pers[b*8 +: 8] = wb_dat_i[b*8 +: 8];
         end
         if (wb_sel_i[0] && wb_adr_i == A_CTRL) n.perf = wb_dat_i[0];
      end

      // Running operations and the suspend latency.
      unique case (q.st)
         ST_IDLE, ST_SUSP: begin
         end
         ST_BUSY: begin
            if (q.lat != '0) n.lat = q.lat - 24'h00_0001;
            if (q.cnt <= 24'h00_0001) begin
               n.st  = ST_IDLE;
               n.write_enable_latch = 1'b0;
               n.write_in_progress = 1'b0;
            end else begin
               n.cnt = q.cnt - 24'h00_0001;
            end
         end
         ST_SUSP_WAIT: begin
            if (q.lat <= 24'h00_0001) begin
               n.st  = ST_SUSP;
               n.write_enable_latch = 1'b0;
               n.write_in_progress = 1'b0;
               n.lat = '0;
               if (q.opk == OPK_PROG) n.program_suspended_flag = 1'b1;
               else n.erase_suspended_flag = 1'b1;
            end else begin
               n.lat = q.lat - 24'h00_0001;
            end
         end
         ST_NEST: begin
            if (q.cnt <= 24'h00_0001) begin
               n.st  = ST_SUSP;
               n.write_enable_latch = 1'b0;
               n.write_in_progress = 1'b0;
               n.cnt = q.sav;
            end else begin
               n.cnt = q.cnt - 24'h00_0001;
            end
         end
      endcase

      if (lk.valid) begin
         n.armed = 1'b0;
         unique case (lk.opcode)
            OP_RESET_ARM_CMD: begin
               acc     = 1'b1;
               n.armed = 1'b1;
            end
            OP_RST: begin
               acc = 1'b1;
               if (q.armed) begin
                  // Any running operation is dropped; its target data is not trustworthy.
                  n.st   = ST_IDLE;
                  n.write_enable_latch  = 1'b0;
                  n.write_in_progress  = 1'b0;
                  n.program_suspended_flag  = 1'b0;
                  n.erase_suspended_flag  = 1'b0;
                  n.quad = 1'b0;
                  n.rdok = 1'b0;
                  n.vol  = VOL_RST;
                  n.cnt  = '0;
                  n.lat  = '0;
               end
            end
            OP_NOP, OP_STATUS_READ_CMD, OP_CONFIG_READ_CMD, OP_SECURITY_REG_READ_CMD, OP_SIG_RD: acc = 1'b1;
            OP_CLEAR_WRITE_LATCH_CMD: begin
               acc = 1'b1;
               if (q.st != ST_BUSY && q.st != ST_NEST) n.write_enable_latch = 1'b0;
            end
            OP_SET_WRITE_LATCH_CMD: if (idle || sus) begin
               acc   = 1'b1;
               n.write_enable_latch = 1'b1;
            end
            OP_QUAD_ENTER, OP_QUAD_EXIT: if (idle || sus) begin
               acc    = 1'b1;
               n.quad = (lk.opcode == OP_QUAD_ENTER);
            end
            OP_READ, OP_FAST_READ, OP_DOUT_READ, OP_QOUT_READ, OP_DIO_READ,
            OP_QIO_READ, OP_WQ_READ: if (idle || sus) begin
               acc    = 1'b1;
               n.rdok = idle || !hit;
            end
            OP_PARAM_RD, OP_IDENT_RD, OP_QIDENT_RD, OP_MAKER_RD, OP_SEC_ENTER,
            OP_SEC_EXIT, OP_BURST_SET, OP_LOCK_RD, OP_PBIT_RD, OP_VBIT_RD: begin
               acc = idle || sus;
            end
            OP_RESUME_A, OP_RESUME_B: if (sus && !q.perf) begin
               acc   = 1'b1;
               n.st  = ST_BUSY;
               n.write_enable_latch = 1'b1;
               n.write_in_progress = 1'b1;
               n.program_suspended_flag = 1'b0;
               n.erase_suspended_flag = 1'b0;
               n.lat = (q.opk == OPK_PROG) ? P_GAP_CYC : E_GAP_CYC;
            end
            OP_PP, OP_QPP: begin
               // Latch must be set first; outside region and unprotected only.
               if (q.write_enable_latch && lk.has_addr && !prot && (idle || (sus && q.erase_suspended_flag && !hit))) begin
                  acc   = 1'b1;
                  n.write_enable_latch = 1'b1;
                  n.write_in_progress = 1'b1;
                  n.cnt = PROG_CYC;
                  if (idle) begin
                     n.st   = ST_BUSY;
                     n.opk  = OPK_PROG;
                     n.addr = lk.addr;
                     n.lat  = '0;
                  end else begin
                     n.st  = ST_NEST;
                     n.sav = q.cnt;
                  end
               end
            end
            OP_SE4K, OP_BE32K, OP_BE64K: begin
               if (idle && q.write_enable_latch && lk.has_addr && !prot) begin
                  acc    = 1'b1;
                  n.st   = ST_BUSY;
                  n.write_in_progress  = 1'b1;
                  n.addr = lk.addr;
                  n.cnt  = ERASE_CYC;
                  n.lat  = '0;
                  n.opk  = (lk.opcode == OP_SE4K) ? OPK_E4K :
                           (lk.opcode == OP_BE32K) ? OPK_E32K : OPK_E64K;
               end
            end
            default: begin
               // A nested program fails the ST_BUSY check here, so it cannot be suspended.
               if (lk.opcode == SUSPEND_OP && q.st == ST_BUSY && q.lat == '0
                   && q.cnt > 24'h00_0001) begin
                  acc  = 1'b1;
                  n.st = ST_SUSP_WAIT;
                  n.lat = (q.opk == OPK_PROG) ? P_SL_CYC : E_SL_CYC;
               end
            end
         endcase
         n.last_op  = lk.opcode;
         n.last_acc = acc;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q      <= '0;
         q.vol  <= VOL_RST;
         q.pers <= PERS_RST;
      end else if (ce_i) begin
         q <= n;
      end
   end

   assign lk.quad  = q.quad;
   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   prot_blocks_write_a: assert property (
      ce_i && lk.valid && idle && prot && lk.opcode == OP_SE4K |=> q.st == ST_IDLE)
      else $error("erase started on a protected region");
   suspended_read_a: assert property (
      ce_i && lk.valid && sus && hit && lk.opcode == OP_READ |=> !q.rdok)
      else $error("read of the suspended region was allowed");
   susp_latency_a: assert property (
      $rose(q.program_suspended_flag | q.erase_suspended_flag) |-> $past(q.st) == ST_SUSP_WAIT && !q.write_enable_latch)
      else $error("suspended flag set without the latency");
   late_cmd_a: assert property (
      lk.valid && q.st == ST_SUSP_WAIT && lk.opcode == OP_SET_WRITE_LATCH_CMD |-> !acc)
      else $error("latency-bound command taken too early");
   pp_in_psusp_a: assert property (
      lk.valid && q.program_suspended_flag && lk.opcode == OP_PP |-> !acc)
      else $error("page program taken during program suspend");
   early_cmd_a: assert property (
      lk.valid && q.st != ST_IDLE && lk.opcode == OP_STATUS_READ_CMD |-> acc)
      else $error("status read refused during suspend");
   flags_excl_a: assert property (
      !(q.program_suspended_flag && q.erase_suspended_flag) && (q.program_suspended_flag || q.erase_suspended_flag) == (sus || q.st == ST_NEST))
      else $error("suspended flags disagree with the state");
   nest_nosusp_a: assert property (
      ce_i && q.st == ST_NEST && lk.valid && lk.opcode == SUSPEND_OP
      |=> q.st inside {ST_NEST, ST_SUSP})
      else $error("nested program was suspended");
   nest_flags_a: assert property (
      q.st == ST_NEST |-> q.write_enable_latch && q.write_in_progress && q.erase_suspended_flag)
      else $error("nested program lost its busy flags");
   resume_sets_a: assert property (
      ce_i && lk.valid && sus && !q.perf && lk.opcode == OP_RESUME_A
      |=> q.write_enable_latch && q.write_in_progress && !q.program_suspended_flag && !q.erase_suspended_flag && q.st == ST_BUSY)
      else $error("resume did not restart the operation");
   perf_resume_a: assert property (
      ce_i && lk.valid && sus && q.perf && lk.opcode == OP_RESUME_B |=> sus)
      else $error("resume taken in performance enhance mode");
   nop_disarm_a: assert property (
      ce_i && lk.valid && lk.opcode == OP_NOP && (idle || sus) |=> !q.armed && $stable(q.st))
      else $error("no-op did more than cancel the arm");
   reset_pair_a: assert property (
      ce_i && lk.valid && q.armed && lk.opcode == OP_RST
      |=> q.st == ST_IDLE && !q.write_enable_latch && !q.write_in_progress && q.vol == VOL_RST)
      else $error("armed reset did not restore defaults");
endmodule

/* core/fsr_pkg.sv */
package fsr_pkg;
   localparam int CLK_NS = 40;

   // Command opcodes seen on the serial link.
   localparam logic [7:0] OP_NOP        = 8'h00;
   localparam logic [7:0] OP_PP         = 8'h02;
   localparam logic [7:0] OP_READ       = 8'h03;
   localparam logic [7:0] OP_CLEAR_WRITE_LATCH_CMD       = 8'h04;
   localparam logic [7:0] OP_STATUS_READ_CMD       = 8'h05;
   localparam logic [7:0] OP_SET_WRITE_LATCH_CMD       = 8'h06;
   localparam logic [7:0] OP_FAST_READ  = 8'h0B;
   localparam logic [7:0] OP_CONFIG_READ_CMD       = 8'h15;
   localparam logic [7:0] OP_SE4K       = 8'h20;
   localparam logic [7:0] OP_SECURITY_REG_READ_CMD     = 8'h2B;
   localparam logic [7:0] OP_LOCK_RD    = 8'h2D;
   localparam logic [7:0] OP_RESUME_B   = 8'h30;
   localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
   localparam logic [7:0] OP_QPP        = 8'h38;
   localparam logic [7:0] OP_DOUT_READ  = 8'h3B;
   localparam logic [7:0] OP_BE32K      = 8'h52;
   localparam logic [7:0] OP_PARAM_RD   = 8'h5A;
   localparam logic [7:0] OP_RESET_ARM_CMD      = 8'h66;
   localparam logic [7:0] OP_QOUT_READ  = 8'h6B;
   localparam logic [7:0] OP_RESUME_A   = 8'h7A;
   localparam logic [7:0] OP_MAKER_RD   = 8'h90;
   localparam logic [7:0] OP_RST        = 8'h99;
   localparam logic [7:0] OP_IDENT_RD   = 8'h9F;
   localparam logic [7:0] OP_SIG_RD     = 8'hAB;
   localparam logic [7:0] OP_QIDENT_RD  = 8'hAF;
   localparam logic [7:0] OP_SUSP_DEF   = 8'hB0;
   localparam logic [7:0] OP_SEC_ENTER  = 8'hB1;
   localparam logic [7:0] OP_DIO_READ   = 8'hBB;
   localparam logic [7:0] OP_BURST_SET  = 8'hC0;
   localparam logic [7:0] OP_SEC_EXIT   = 8'hC1;
   localparam logic [7:0] OP_BE64K      = 8'hD8;
   localparam logic [7:0] OP_VBIT_RD    = 8'hE0;
   localparam logic [7:0] OP_PBIT_RD    = 8'hE2;
   localparam logic [7:0] OP_WQ_READ    = 8'hE7;
   localparam logic [7:0] OP_QIO_READ   = 8'hEB;
   localparam logic [7:0] OP_QUAD_EXIT  = 8'hF5;

   // Address layout and the link framing.
   localparam int ADR_W     = 24;
   localparam int PAGE_LSB  = 8;
   localparam int SEC_LSB   = 12;
   localparam int B32_LSB   = 15;
   localparam int B64_LSB   = 16;
   localparam int REG_LSB   = 20;
   localparam int NREG      = 16;
   localparam logic [5:0] OP_BITS   = 6'h08;
   localparam logic [5:0] FULL_BITS = 6'h20;

   // Register offsets and field positions.
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_SECUR  = 8'h04;
   localparam logic [7:0] A_VOL    = 8'h08;
   localparam logic [7:0] A_PERS   = 8'h0C;
   localparam logic [7:0] A_CTRL   = 8'h10;
   localparam logic [7:0] A_LAST   = 8'h14;
   localparam int B_WIP = 0, B_WEL = 1, B_PSB = 2, B_ESB = 3;
   localparam int B_QUAD = 4, B_ARM = 5, B_RDOK = 6, B_BUSY = 7;
   localparam int SEC_PSB = 2, SEC_ESB = 3, LAST_ACC = 8;
   localparam logic [15:0] VOL_RST  = 16'hFFFF;
   localparam logic [15:0] PERS_RST = 16'h0000;

   typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_SUSP_WAIT, ST_SUSP, ST_NEST} fsr_state_t;
   typedef enum logic [1:0] {OPK_PROG, OPK_E4K, OPK_E32K, OPK_E64K} fsr_opk_t;

   function automatic int fsr_cyc_up(int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
endpackage

/* core/fsr_cmd_if.sv */
`timescale 1ns/1ps
interface fsr_cmd_if;
   logic        valid;
   logic [7:0]  opcode;
   logic [23:0] addr;
   logic        has_addr;
   logic        quad;
   modport shifter (output valid, output opcode, output addr, output has_addr, input quad);
   modport core    (input valid, input opcode, input addr, input has_addr, output quad);
endinterface

/* core/fsr_cmd_shift.sv */
`timescale 1ns/1ps
module fsr_cmd_shift
   import fsr_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       sclk_i,
   input  wire logic       cs_n_i,
   input  wire logic [3:0] sio_i,
   fsr_cmd_if.shifter      lk
);
   typedef struct packed {
      logic [1:0]  sck;
      logic        sck_q;
      logic [1:0]  csn;
      logic        csn_q;
      logic [3:0]  d1;
      logic [3:0]  d2;
      logic [5:0]  nbit;
      logic [7:0]  op;
      logic [23:0] adr;
      logic        vld;
   } fsr_shf_t;

   fsr_shf_t q;
   fsr_shf_t n;

   always_comb begin
      n       = q;
      n.sck   = {q.sck[0], sclk_i};
      n.csn   = {q.csn[0], cs_n_i};
      n.d1    = sio_i;
      n.d2    = q.d1;
      n.sck_q = q.sck[1];
      n.csn_q = q.csn[1];
      n.vld   = 1'b0;
      if (q.csn[1] && !q.csn_q) begin
         // A frame shorter than a whole opcode is dropped.
         n.vld = (q.nbit >= OP_BITS);
      end else if (!q.csn[1] && q.csn_q) begin
         n.nbit = '0;
      end else if (!q.csn[1] && q.sck[1] && !q.sck_q && q.nbit < FULL_BITS) begin
         if (lk.quad) begin
            if (q.nbit < OP_BITS) n.op = {q.op[3:0], q.d2};
            else n.adr = {q.adr[19:0], q.d2};
            n.nbit = q.nbit + 6'h04;
         end else begin
            // Only the lowest line carries data in single-line mode.
            if (q.nbit < OP_BITS) n.op = {q.op[6:0], q.d2[0]};
            else n.adr = {q.adr[22:0], q.d2[0]};
            n.nbit = q.nbit + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q     <= '0;
         q.sck <= 2'h0;
         q.csn <= 2'h3;
         q.csn_q <= 1'b1;
      end else if (ce_i) begin
         q <= n;
      end
   end

   assign lk.valid    = q.vld;
   assign lk.opcode   = q.op;
   assign lk.addr     = q.adr;
   assign lk.has_addr = (q.nbit == FULL_BITS);
endmodule

/* tb/fsr_host.sv */
`timescale 1ns/1ps
module fsr_host (
   input  wire logic       clk_i,
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic [3:0]      sio_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sio_o  = 4'h0;
   end

   // The link clock stands still between frames and each bit, or each nibble in quad mode, spans eight system clocks.
   task automatic frame(input logic [31:0] w, input int nb, input bit q);
      int k;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      for (k = 0; k < nb; k += (q ? 4 : 1)) begin
         sio_o <= q ? w[31-k -: 4] : {~sio_o[3:1], w[31-k]};
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      sio_o  <= ~sio_o;
      repeat (8) @(posedge clk_i);
   endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import fsr_pkg::*;
();
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        req   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] wdat  = 32'h0000_0000;
   logic [31:0] seed  = 32'h0000_1b6c;
   logic        ce    = 1'b1;
   logic [3:0]  sel   = 4'hf;
   logic [3:0]  bsel  = 4'hf;
   logic [31:0] rdat;
   logic        ack;
   logic        sclk;
   logic        cs_n;
   logic [3:0]  sio;
   int          bad_count;
   int          comparisons;
   int          m_wip, m_wel, m_psb, m_esb, m_q, m_arm, m_rd, m_bsy, k;
   logic [7:0]  okl [26] = '{OP_READ, OP_FAST_READ, OP_DOUT_READ, OP_QOUT_READ, OP_DIO_READ,
      OP_QIO_READ, OP_WQ_READ, OP_PARAM_RD, OP_IDENT_RD, OP_QIDENT_RD, OP_MAKER_RD,
      OP_QUAD_ENTER, OP_QUAD_EXIT, OP_SEC_ENTER, OP_SEC_EXIT, OP_BURST_SET, OP_LOCK_RD,
      OP_PBIT_RD, OP_VBIT_RD, OP_CLEAR_WRITE_LATCH_CMD, OP_STATUS_READ_CMD, OP_CONFIG_READ_CMD, OP_SECURITY_REG_READ_CMD, OP_SIG_RD, OP_NOP, OP_SET_WRITE_LATCH_CMD};

   always #(CLK_NS / 2) clk_i = ~clk_i;

   fsr_top #(.P_SUSP_NS(8000), .E_SUSP_NS(400), .P_GAP_NS(400), .E_GAP_NS(400),
      .PROG_NS(20000), .ERASE_NS(40000)) fsr_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .sclk_i(sclk), .cs_n_i(cs_n), .sio_i(sio),
      .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   fsr_host fsr_host_i (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .sio_o(sio));

   function logic [19:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[19:0];
   endfunction

   function automatic logic [31:0] ms();
      return 32'(m_wip + 2*m_wel + 4*m_psb + 8*m_esb + 16*m_q + 32*m_arm + 64*m_rd + 128*m_bsy);
   endfunction

   task automatic stop_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      req  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= bsel;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      req <= 1'b0;
      if (n >= 50) bad_count++;
   endtask

   task automatic ws(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rs(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(q & m, e & m);
   endtask

   task automatic sts(input logic [31:0] m = 32'h0000_00ff);
      rs(A_STATUS, ms(), m);
   endtask

   // A zero address means the frame carries the opcode alone.
   task automatic cmd(input logic [7:0] op, input logic [23:0] a = 24'h00_0000);
      fsr_host_i.frame({op, a}, (a != 0) ? 32 : 8, m_q != 0);
   endtask

   task automatic wait_done();
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         wb(1'b0, A_STATUS, 32'h0000_0000, q);
         n++;
      end while (q[0] !== 1'b0 && n < 400);
      if (n >= 400) bad_count++;
      m_wip = 0;
      m_wel = 0;
   endtask

   initial begin
      repeat (60000) @(posedge clk_i);
      bad_count++;
      stop_test();
   end

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rs(A_VOL, 32'h0000_ffff);
      bsel = 4'h1;
      ws(A_VOL, 32'h0000_0000);
      bsel = 4'hf;
      rs(A_VOL, 32'h0000_ff00);
      ws(A_STATUS, 32'h0000_00ff);
      rs(8'h18, 32'h0000_0000);
      sts();
      cmd(OP_QUAD_ENTER);
      m_q = 1;
      cmd(OP_RESET_ARM_CMD);
      m_arm = 1;
      sts();
      cmd(OP_NOP);
      m_arm = 0;
      sts();
      cmd(OP_QUAD_EXIT);
      m_q = 0;
      cmd(OP_RESET_ARM_CMD);
      cmd(OP_SET_WRITE_LATCH_CMD);
      cmd(OP_RST);
      m_wel = 1;
      sts();
      ws(A_VOL, 32'h0000_0000);
      cmd(OP_RESET_ARM_CMD);
      cmd(OP_RST);
      m_wel = 0;
      sts();
      rs(A_VOL, 32'h0000_ffff);
      for (k = 0; k < 4; k++) begin
         ws(A_VOL, 32'((k % 2) * 2));
         ws(A_PERS, 32'((k / 2) * 2));
         cmd(OP_SET_WRITE_LATCH_CMD);
         cmd(OP_PP, {4'h1, rnd()});
         rs(A_LAST, {23'h0, k == 0, OP_PP});
         if (k == 0) begin
            // A low clock enable must stall the running program.
            ce <= 1'b0;
            repeat (600) @(posedge clk_i);
            ce <= 1'b1;
            m_wip = 1;
            m_wel = 1;
            m_bsy = 1;
            sts();
            wait_done();
            m_bsy = 0;
         end else begin
            cmd(OP_SE4K, {4'h1, rnd()});
            rs(A_LAST, {23'h0, OP_SE4K});
         end
      end
      ws(A_VOL, 32'h0000_0000);
      ws(A_PERS, 32'h0000_0000);
      cmd(OP_CLEAR_WRITE_LATCH_CMD);
      cmd(OP_SET_WRITE_LATCH_CMD);
      cmd(OP_SE4K, 24'h00_1000);
      m_bsy = 1;
      cmd(OP_SUSP_DEF);
      repeat (12) @(posedge clk_i);
      m_esb = 1;
      sts();
      rs(A_SECUR, 32'h0000_0008);
      for (k = 0; k < 26; k++) begin
         cmd(okl[k], {4'h3, rnd()});
         rs(A_LAST, {23'h1, okl[k]});
         m_q = (okl[k] == OP_QUAD_ENTER) ? 1 : (okl[k] == OP_QUAD_EXIT) ? 0 : m_q;
      end
      m_wel = 1;
      m_rd  = 1;
      sts();
      cmd(OP_READ, {12'h001, 12'(rnd())});
      m_rd = 0;
      sts();
      cmd(OP_PP, {4'h2, rnd()});
      rs(A_STATUS, 32'h0000_0003, 32'h0000_0003);
      cmd(OP_SUSP_DEF);
      cmd(OP_RESUME_A);
      rs(A_STATUS, 32'h0000_0003, 32'h0000_0003);
      wait_done();
      sts();
      cmd(OP_SET_WRITE_LATCH_CMD);
      cmd(OP_PP, 24'h00_1100);
      rs(A_LAST, {23'h0, OP_PP});
      cmd(OP_CLEAR_WRITE_LATCH_CMD);
      ws(A_CTRL, 32'h0000_0001);
      cmd(OP_RESUME_B);
      sts();
      ws(A_CTRL, 32'h0000_0000);
      cmd(OP_RESUME_A);
      m_wip = 1;
      m_wel = 1;
      m_esb = 0;
      sts();
      rs(A_SECUR, 32'h0000_0000);
      cmd(OP_RESET_ARM_CMD);
      cmd(OP_RST);
      m_wip = 0;
      m_wel = 0;
      m_bsy = 0;
      sts(32'h0000_00bf);
      // Recovery is scaled down with the shortened operation times.
      repeat (1000) @(posedge clk_i);
      ws(A_VOL, 32'h0000_0000);
      cmd(OP_SET_WRITE_LATCH_CMD);
      cmd(OP_PP, {4'h4, rnd()});
      cmd(OP_SUSP_DEF);
      // The program latency outlasts two frames, so both command lists meet it.
      cmd(OP_SET_WRITE_LATCH_CMD);
      rs(A_LAST, {23'h0, OP_SET_WRITE_LATCH_CMD});
      cmd(OP_STATUS_READ_CMD);
      rs(A_LAST, {23'h1, OP_STATUS_READ_CMD});
      repeat (60) @(posedge clk_i);
      m_psb = 1;
      m_bsy = 1;
      sts(32'h0000_00bf);
      rs(A_SECUR, 32'h0000_0004);
      cmd(OP_SET_WRITE_LATCH_CMD);
      m_wel = 1;
      cmd(OP_PP, {4'h5, rnd()});
      rs(A_LAST, {23'h0, OP_PP});
      cmd(OP_QPP, {4'h5, rnd()});
      rs(A_LAST, {23'h0, OP_QPP});
      cmd(OP_SE4K, 24'h60_0000);
      rs(A_LAST, {23'h0, OP_SE4K});
      sts(32'h0000_00bf);
      cmd(OP_RESUME_B);
      m_psb = 0;
      m_wip = 1;
      sts(32'h0000_00bf);
      rs(A_SECUR, 32'h0000_0000);
      wait_done();
      m_bsy = 0;
      sts(32'h0000_00bf);
      stop_test();
   end
endmodule
